// ===== bench/flash_data_sequencer_tb.sv
// Self-checking testbench for the nonvolatile array command sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module flash_data_sequencer_tb;
   import nv_seq_pkg::*;
   // Short counts; the array clear still needs its 4096-cycle walk
   localparam int PP    = 20;
   localparam int BP    = 24;
   localparam int BIG   = 28;
   localparam int ER    = 8200;
   localparam int LIMIT = 60000;
   ////////////////////////////////////////////////////////////////////////
   logic       CLK_SYS, RESETN, ADDR_HIGH_WE, ADDR_LOW_WE, COMMAND_WE;
   logic [3:0] DATA_WE;
   logic [7:0] WRITE_DATA, PAGE_ADDR_HIGH, PAGE_ADDR_LOW, NV_COMMAND_REG;
   logic [7:0] PAGE_DATA_BYTE0, PAGE_DATA_BYTE1;
   logic [7:0] PAGE_DATA_BYTE2, PAGE_DATA_BYTE3;
   logic       PROGRAM_MEMORY_MODE, CORE_STALL, IRQ_BLOCK;
   // Reference model of array and registers
   logic [7:0] mem [0:BYTE_COUNT-1];
   logic [7:0] d [4];
   logic [7:0] ah, al, st;
   logic       pm;
   logic [7:0] bad [6] = '{8'h03, 8'h00, 8'h07, 8'h80, 8'h83, 8'hFF};
   logic [7:0] ops [5] = '{CMD_PAGE_READ, CMD_PAGE_PROGRAM, CMD_PAGE_CHECK,
                           CMD_SINGLE_READ, CMD_SINGLE_PROGRAM};
   int         errors, checks_done, cyc, k;
   int unsigned seed;
   ////////////////////////////////////////////////////////////////////////
   flash_data_sequencer #(.PAGE_PROG_CYCLES(PP), .BYTE_PROG_CYCLES(BP),
      .ERASE_CYCLES(ER), .BIG_PROG_CYCLES(BIG)) i_dut (
      .CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR_HIGH_WE(ADDR_HIGH_WE),
      .ADDR_LOW_WE(ADDR_LOW_WE), .DATA_WE(DATA_WE), .COMMAND_WE(COMMAND_WE),
      .WRITE_DATA(WRITE_DATA), .PAGE_ADDR_HIGH(PAGE_ADDR_HIGH),
      .PAGE_ADDR_LOW(PAGE_ADDR_LOW), .PAGE_DATA_BYTE0(PAGE_DATA_BYTE0),
      .PAGE_DATA_BYTE1(PAGE_DATA_BYTE1), .PAGE_DATA_BYTE2(PAGE_DATA_BYTE2),
      .PAGE_DATA_BYTE3(PAGE_DATA_BYTE3), .NV_COMMAND_REG(NV_COMMAND_REG),
      .PROGRAM_MEMORY_MODE(PROGRAM_MEMORY_MODE), .CORE_STALL(CORE_STALL),
      .IRQ_BLOCK(IRQ_BLOCK));
   ////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   always #12.5 CLK_SYS = ~CLK_SYS;
   // Hang guard: a stuck stall must not run forever
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc >= LIMIT) begin
         errors++;
         results();
      end
   end
   // Verdict and end of run
   task automatic results;
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Every visible register against the model
   task automatic check_regs;
      `CHK(PAGE_ADDR_HIGH, ah)
      `CHK(PAGE_ADDR_LOW, al)
      `CHK(PAGE_DATA_BYTE0, d[0])
      `CHK(PAGE_DATA_BYTE1, d[1])
      `CHK(PAGE_DATA_BYTE2, d[2])
      `CHK(PAGE_DATA_BYTE3, d[3])
      `CHK(NV_COMMAND_REG, st)
      `CHK(PROGRAM_MEMORY_MODE, pm)
      `CHK(CORE_STALL, 1'b0)
   endtask
   // One register write: 0 high, 1 low, 2..5 data bytes
   task automatic wr(input int sel, input logic [7:0] v);
      @(negedge CLK_SYS);
      WRITE_DATA = v;
      case (sel)
         0: ADDR_HIGH_WE = 1'b1;
         1: ADDR_LOW_WE = 1'b1;
         default: DATA_WE[sel-2] = 1'b1;
      endcase
      @(negedge CLK_SYS);
      {ADDR_HIGH_WE, ADDR_LOW_WE, DATA_WE} = 6'h00;
      case (sel)
         0: ah = v;
         1: al = v;
         default: d[sel-2] = v;
      endcase
   endtask
   // Command write, stall timing, then model update and compare
   task automatic run(input logic [7:0] code, input bit poke);
      int n, en, i, b;
      logic ok;
      @(negedge CLK_SYS);
      COMMAND_WE = 1'b1;
      WRITE_DATA = code;
      @(negedge CLK_SYS);
      COMMAND_WE = 1'b0;
      n = 0;
      // First look is half a cycle after the edge that took the command
      for (i = 0; i < 90000; i++) begin
         `CHK(IRQ_BLOCK, CORE_STALL)
         if (CORE_STALL !== 1'b1)
            break;
         n++;
         // Writes while stalled must be dropped
         ADDR_HIGH_WE = poke && (n == 2);
         DATA_WE = {4{poke && (n == 2)}};
         WRITE_DATA = 8'h5A;
         @(negedge CLK_SYS);
      end
      en = 0;
      b = {ah[1:0], al, 2'b00};
      ok = 1'b1;
      case (code)
         CMD_PAGE_READ: begin
            en = PAGE_READ_CYC;
            for (i = 0; i < 4; i++)
               d[i] = mem[b+i];
         end
         CMD_PAGE_PROGRAM: begin
            en = pm ? BIG : PP;
            for (i = 0; i < 4; i++)
               if (!pm)
                  mem[b+i] &= d[i];
         end
         CMD_PAGE_CHECK: en = PAGE_READ_CYC;
         CMD_PAGE_CLEAR: begin
            en = ER;
            for (i = 0; i < 4; i++)
               if (!pm)
                  mem[b+i] = ERASED_BYTE;
         end
         CMD_ARRAY_CLEAR: begin
            en = ER;
            for (i = 0; i < BYTE_COUNT; i++)
               if (!pm)
                  mem[i] = ERASED_BYTE;
         end
         CMD_SINGLE_READ: begin
            en = BYTE_READ_CYC;
            d[0] = mem[{ah[3:0], al}];
         end
         CMD_SINGLE_PROGRAM: begin
            en = BP;
            if (!pm)
               mem[{ah[3:0], al}] &= d[0];
         end
         CMD_PROGRAM_MEMORY_MODE: pm = 1'b1;
         CMD_LEAVE_PROGRAM_MEMORY_MODE: pm = 1'b0;
         default: en = 0;
      endcase
      for (i = 0; i < 4; i++)
         if (mem[b+i] !== d[i])
            ok = 1'b0;
      if (en != 0)
         st = (code == CMD_PAGE_CHECK) ? (ok ? STATUS_OK : STATUS_BAD) : code;
      `CHK(n, en)
      check_regs();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {CLK_SYS, RESETN, ADDR_HIGH_WE, ADDR_LOW_WE, COMMAND_WE} = 5'h00;
      DATA_WE = 4'h0;
      WRITE_DATA = 8'h00;
      {ah, al, st, pm} = {ADDR_RESET, ADDR_RESET, STATUS_OK, 1'b0};
      d = '{4{DATA_RESET}};
      seed = $urandom(12171);
      repeat (20) @(negedge CLK_SYS);
      check_regs();
      RESETN = 1'b1;
      run(CMD_ARRAY_CLEAR, 1'b0);
      wr(0, 8'hFF);
      wr(1, 8'hFF);
      run(CMD_PAGE_READ, 1'b0);
      // Change one byte, keep the rest of the page
      for (k = 0; k < 3; k++) begin
         wr(0, 8'($urandom));
         wr(1, 8'($urandom));
         run(CMD_PAGE_READ, 1'b0);
         wr(3, 8'hF3);
         run(CMD_PAGE_CLEAR, 1'b0);
         run(CMD_PAGE_PROGRAM, 1'b0);
         run(CMD_PAGE_CHECK, 1'b0);
         `CHK(NV_COMMAND_REG, STATUS_OK)
      end
      // Programming only clears bits, so a later check fails
      wr(2, 8'h00);
      run(CMD_PAGE_PROGRAM, 1'b0);
      wr(2, 8'hFF);
      run(CMD_PAGE_PROGRAM, 1'b0);
      run(CMD_PAGE_CHECK, 1'b0);
      `CHK(NV_COMMAND_REG, STATUS_BAD)
      run(CMD_PAGE_READ, 1'b0);
      // Neighbour page survives a page clear
      wr(1, al ^ 8'h01);
      run(CMD_PAGE_PROGRAM, 1'b0);
      wr(1, al ^ 8'h01);
      run(CMD_PAGE_CLEAR, 1'b0);
      wr(1, al ^ 8'h01);
      run(CMD_PAGE_READ, 1'b0);
      // Single byte program and read back
      wr(0, 8'($urandom));
      wr(1, 8'($urandom));
      wr(2, 8'($urandom));
      run(CMD_SINGLE_PROGRAM, 1'b0);
      wr(2, 8'h00);
      run(CMD_SINGLE_READ, 1'b0);
      for (k = 0; k < 6; k++)
         run(bad[k], 1'b0);
      run(CMD_PAGE_READ, 1'b1);
      // Known cleared byte, so a stray erase below would show
      wr(2, 8'h00);
      run(CMD_PAGE_PROGRAM, 1'b0);
      // Program-memory mode: timing only, array untouched
      run(CMD_PROGRAM_MEMORY_MODE, 1'b0);
      run(CMD_PAGE_PROGRAM, 1'b0);
      run(CMD_SINGLE_PROGRAM, 1'b0);
      run(CMD_ARRAY_CLEAR, 1'b0);
      run(CMD_LEAVE_PROGRAM_MEMORY_MODE, 1'b0);
      run(CMD_PAGE_READ, 1'b0);
      // Random traffic against the model
      for (k = 0; k < 30; k++) begin
         wr(0, 8'($urandom));
         wr(1, 8'($urandom));
         wr($urandom_range(5, 2), 8'($urandom));
         run(ops[$urandom_range(4, 0)], 1'b0);
      end
      // Reset in the middle of an operation
      @(negedge CLK_SYS);
      COMMAND_WE = 1'b1;
      WRITE_DATA = CMD_PAGE_READ;
      @(negedge CLK_SYS);
      COMMAND_WE = 1'b0;
      repeat (5) @(negedge CLK_SYS);
      RESETN = 1'b0;
      {ah, al, st, pm} = {ADDR_RESET, ADDR_RESET, STATUS_OK, 1'b0};
      d = '{4{DATA_RESET}};
      @(negedge CLK_SYS);
      check_regs();
      RESETN = 1'b1;
      run(CMD_PAGE_READ, 1'b0);
      results();
   end
endmodule
`default_nettype wire

// ===== pkg/nv_seq_pkg.sv
// Package: constants and types for the nonvolatile data array sequencer
package nv_seq_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned CORE_PER_MC     = 12;
   localparam int unsigned PAGE_READ_MC    = 5;
   localparam int unsigned BYTE_READ_MC    = 3;
   localparam int unsigned PAGE_PROG_US    = 380;
   localparam int unsigned BYTE_PROG_US    = 200;
   localparam int unsigned ERASE_MS        = 2;
   localparam int unsigned BIG_PROG_MS     = 15;
   localparam int unsigned PAGE_READ_CYC   = PAGE_READ_MC * CORE_PER_MC;
   localparam int unsigned BYTE_READ_CYC   = BYTE_READ_MC * CORE_PER_MC;
   localparam int unsigned PAGE_PROG_CYC   = PAGE_PROG_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BYTE_PROG_CYC   = BYTE_PROG_US * (CLK_HZ / 1_000_000);
   localparam int unsigned ERASE_CYC       = ERASE_MS * (CLK_HZ / 1_000);
   localparam int unsigned BIG_PROG_CYC    = BIG_PROG_MS * (CLK_HZ / 1_000);
   localparam int unsigned CNT_W           = 20;
   // Array geometry
   localparam int unsigned PAGE_COUNT      = 1024;
   localparam int unsigned PAGE_BYTES      = 4;
   localparam int unsigned BYTE_COUNT      = PAGE_COUNT * PAGE_BYTES;
   localparam int unsigned PAGE_AW         = 10;
   localparam int unsigned BYTE_AW         = 12;
   // Values
   localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
   localparam logic [7:0]  DATA_RESET      = 8'h00;
   localparam logic [7:0]  ADDR_RESET      = 8'h00;
   localparam logic [7:0]  STATUS_OK       = 8'h00;
   localparam logic [7:0]  STATUS_BAD      = 8'h01;
   // Command codes
   localparam logic [7:0]  CMD_PAGE_READ      = 8'h01;
   localparam logic [7:0]  CMD_PAGE_PROGRAM   = 8'h02;
   localparam logic [7:0]  CMD_PAGE_CHECK     = 8'h04;
   localparam logic [7:0]  CMD_PAGE_CLEAR     = 8'h05;
   localparam logic [7:0]  CMD_ARRAY_CLEAR    = 8'h06;
   localparam logic [7:0]  CMD_SINGLE_READ    = 8'h81;
   localparam logic [7:0]  CMD_SINGLE_PROGRAM = 8'h82;
   localparam logic [7:0]  CMD_PROGRAM_MEMORY_MODE = 8'hF0;
   localparam logic [7:0]  CMD_LEAVE_PROGRAM_MEMORY_MODE = 8'h0F;
   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CLEAR} seq_state_t;
endpackage

// ===== src/flash_data_sequencer.sv
// Command sequencer for the four-byte-page nonvolatile data array
//
// Notes on behaviour
// - Page address from high and low bytes
// - Code 1 copies page into data registers
// - Programming only clears bits; erase first
// - Erase acts on whole four-byte pages
// - Codes 5 erase, 2 program, 4 check
// - Code 06H erases whole array
// - Data-array durations per operation
// - Program-memory mode durations differ
// - Operation starts on command write
// - Core stalled until operation completes
// - Interrupt service blocked while busy
// - Timers keep running during stall
// - 1024 pages of four bytes
// - Mismatch on check reads nonzero
// - F0H enters, 0FH leaves program-memory mode
// - 81H reads byte, 82H programs byte
`timescale 1ns/1ps
`default_nettype none
module flash_data_sequencer
   import nv_seq_pkg::*;
#(
   parameter int unsigned PAGE_PROG_CYCLES = PAGE_PROG_CYC,
   parameter int unsigned BYTE_PROG_CYCLES = BYTE_PROG_CYC,
   parameter int unsigned ERASE_CYCLES     = ERASE_CYC,
   parameter int unsigned BIG_PROG_CYCLES  = BIG_PROG_CYC
) (
   // Clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RESETN,
   // Register writes from the core
   input  wire logic       ADDR_HIGH_WE,
   input  wire logic       ADDR_LOW_WE,
   input  wire logic [3:0] DATA_WE,
   input  wire logic       COMMAND_WE,
   input  wire logic [7:0] WRITE_DATA,
   // Register contents seen by the core
   output logic [7:0]      PAGE_ADDR_HIGH,
   output logic [7:0]      PAGE_ADDR_LOW,
   output logic [7:0]      PAGE_DATA_BYTE0,
   output logic [7:0]      PAGE_DATA_BYTE1,
   output logic [7:0]      PAGE_DATA_BYTE2,
   output logic [7:0]      PAGE_DATA_BYTE3,
   output logic [7:0]      NV_COMMAND_REG,
   output logic            PROGRAM_MEMORY_MODE,
   // Core control
   output logic            CORE_STALL,
   output logic            IRQ_BLOCK
);
   import nv_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Storage and state
   // 1024 four-byte pages
   logic [7:0]       mem [BYTE_COUNT];      // Data array
   logic [7:0]       addr_high_reg;         // High address byte
   logic [7:0]       addr_low_reg;          // Low address byte
   logic [7:0]       data_reg [PAGE_BYTES]; // Page data registers
   logic [7:0]       status_reg;            // Command register read value
   logic             pm_mode_reg;           // Program-memory mode flag
   logic             busy_reg;              // Stall to the core
   seq_state_t       state_reg;             // Sequencer state
   logic [CNT_W-1:0] cnt_reg;               // Remaining cycles
   logic [7:0]       op_reg;                // Operation in progress
   logic [BYTE_AW:0] clr_idx_reg;           // Array-clear walk index
   logic [PAGE_AW-1:0] page_addr;           // Page index
   logic [BYTE_AW-1:0] byte_addr;           // Byte index
   logic             cmd_valid;             // Timed command accepted
   logic [CNT_W-1:0] dur;                   // Duration of new command

   // Page address from the two address bytes
   // page address assembly
   assign page_addr = {addr_high_reg[1:0], addr_low_reg};
   assign byte_addr = {addr_high_reg[3:0], addr_low_reg};

   // Duration lookup, mode dependent
   function automatic logic [CNT_W-1:0] op_cycles(input logic [7:0] c,
                                                input logic pm);
      logic [CNT_W-1:0] r;
      r = '0;
      unique case (c)
         CMD_PAGE_READ:      r = CNT_W'(PAGE_READ_CYC);
         CMD_PAGE_CHECK:     r = CNT_W'(PAGE_READ_CYC);
         CMD_SINGLE_READ:    r = CNT_W'(BYTE_READ_CYC);
         CMD_PAGE_PROGRAM:   r = pm ? CNT_W'(BIG_PROG_CYCLES)
                                    : CNT_W'(PAGE_PROG_CYCLES);
         CMD_SINGLE_PROGRAM: r = CNT_W'(BYTE_PROG_CYCLES);
         CMD_PAGE_CLEAR:     r = CNT_W'(ERASE_CYCLES);
         CMD_ARRAY_CLEAR:    r = CNT_W'(ERASE_CYCLES);
         default:            r = '0;
      endcase
      return r;
   endfunction

   assign dur = op_cycles(WRITE_DATA, pm_mode_reg);
   // undefined codes give zero duration and are ignored
   assign cmd_valid = COMMAND_WE && !busy_reg && (dur != '0);

   ////////////////////////////////////////////////////////////////////////
   // Address registers, writable while idle
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         addr_high_reg <= ADDR_RESET;
         addr_low_reg  <= ADDR_RESET;
      end else if (!busy_reg) begin
         if (ADDR_HIGH_WE) begin
            addr_high_reg <= WRITE_DATA;
         end
         if (ADDR_LOW_WE) begin
            addr_low_reg <= WRITE_DATA;
         end
      end
   end

   // Mode switch commands take effect at once, no timing
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         pm_mode_reg <= 1'b0;
      end else if (COMMAND_WE && !busy_reg) begin
         if (WRITE_DATA == CMD_PROGRAM_MEMORY_MODE) begin
            pm_mode_reg <= 1'b1;
         end else if (WRITE_DATA == CMD_LEAVE_PROGRAM_MEMORY_MODE) begin
            pm_mode_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: timing and busy
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= '0;
         op_reg    <= 8'h00;
         busy_reg  <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (cmd_valid) begin
                  op_reg    <= WRITE_DATA;
                  cnt_reg   <= dur - CNT_W'(1);
                  busy_reg  <= 1'b1;
                  state_reg <= (WRITE_DATA == CMD_ARRAY_CLEAR) ?
                               ST_CLEAR : ST_WAIT;
               end
            end
            ST_WAIT, ST_CLEAR: begin
               if (cnt_reg == '0) begin
                  busy_reg  <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
         endcase
      end
   end

   // Array-clear walk index, one byte per cycle, ends well inside 2 ms
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         clr_idx_reg <= '0;
      end else if (cmd_valid && WRITE_DATA == CMD_ARRAY_CLEAR) begin
         clr_idx_reg <= '0;
      end else if (state_reg == ST_CLEAR && !clr_idx_reg[BYTE_AW]) begin
         clr_idx_reg <= clr_idx_reg + (BYTE_AW+1)'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Array contents; the array clear walks from its start, page and byte effects land at the end of the timed operation.
   // Program-memory mode gates off every write in this block, so its commands only
   // time the stall and leave the data array alone.
   wire done_now = (state_reg == ST_WAIT) && (cnt_reg == '0);
   always_ff @(posedge CLK_SYS) begin
      if (state_reg == ST_CLEAR && !clr_idx_reg[BYTE_AW] && !pm_mode_reg) begin
         mem[clr_idx_reg[BYTE_AW-1:0]] <= ERASED_BYTE;
      end else if (done_now && !pm_mode_reg) begin
         unique case (op_reg)
            CMD_PAGE_CLEAR: begin
               for (int i = 0; i < PAGE_BYTES; i++) begin
                  mem[{page_addr, 2'(i)}] <= ERASED_BYTE;
               end
            end
            CMD_PAGE_PROGRAM: begin
               for (int i = 0; i < PAGE_BYTES; i++) begin
                  mem[{page_addr, 2'(i)}] <=
                     mem[{page_addr, 2'(i)}] & data_reg[i];
               end
            end
            CMD_SINGLE_PROGRAM: begin
               mem[byte_addr] <= mem[byte_addr] & data_reg[0];
            end
            default: begin
            end
         endcase
      end
   end

   // Data registers: core writes while idle, reads at completion
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            data_reg[i] <= DATA_RESET;
         end
      end else if (done_now && !pm_mode_reg &&
                   op_reg == CMD_PAGE_READ) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            data_reg[i] <= mem[{page_addr, 2'(i)}];
         end
      end else if (done_now && !pm_mode_reg &&
                   op_reg == CMD_SINGLE_READ) begin
         data_reg[0] <= mem[byte_addr];
      end else if (!busy_reg) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (DATA_WE[i]) begin
               data_reg[i] <= WRITE_DATA;
            end
         end
      end
   end

   // Command register read value: last timed command code, or check result
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         status_reg <= STATUS_OK;
      end else if (done_now && op_reg == CMD_PAGE_CHECK) begin
         status_reg <= STATUS_OK;
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (mem[{page_addr, 2'(i)}] != data_reg[i]) begin
               status_reg <= STATUS_BAD;
            end
         end
      end else if (cmd_valid) begin
         status_reg <= WRITE_DATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign PAGE_ADDR_HIGH      = addr_high_reg;
   assign PAGE_ADDR_LOW       = addr_low_reg;
   assign PAGE_DATA_BYTE0     = data_reg[0];
   assign PAGE_DATA_BYTE1     = data_reg[1];
   assign PAGE_DATA_BYTE2     = data_reg[2];
   assign PAGE_DATA_BYTE3     = data_reg[3];
   assign NV_COMMAND_REG      = status_reg;
   assign PROGRAM_MEMORY_MODE = pm_mode_reg;
   assign CORE_STALL          = busy_reg;
   // interrupts held off; timers outside see no stall
   assign IRQ_BLOCK           = busy_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   // Stall length helper: a plain count replaces a long repetition,
   // which the tools would otherwise have to unroll cycle by cycle
   logic [CNT_W-1:0] stall_len_reg;         // Cycles the stall has stood
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         stall_len_reg <= '0;
      end else if (cmd_valid) begin
         // Restart the count on every accepted command
         stall_len_reg <= '0;
      end else if (busy_reg) begin
         // One more stalled cycle seen
         stall_len_reg <= stall_len_reg + CNT_W'(1);
      end
   end
   sequence s_start;
      cmd_valid;
   endsequence
   a_busy_on_start: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      s_start |=> CORE_STALL) else $error("no stall after command");
   a_read_timing: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      ($fell(CORE_STALL) && op_reg == CMD_PAGE_READ) |->
      stall_len_reg == CNT_W'(PAGE_READ_CYC))
      else $error("page read length wrong");
   a_byte_timing: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      ($fell(CORE_STALL) && op_reg == CMD_SINGLE_READ) |->
      stall_len_reg == CNT_W'(BYTE_READ_CYC))
      else $error("byte read length wrong");
   a_irq_block: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      IRQ_BLOCK == CORE_STALL) else $error("irq block mismatch");
   a_bad_code: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      (COMMAND_WE && !CORE_STALL && dur == '0) |=> !CORE_STALL)
      else $error("undefined code started");
   a_mode_enter: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      (COMMAND_WE && !CORE_STALL && WRITE_DATA == CMD_PROGRAM_MEMORY_MODE)
      |=> PROGRAM_MEMORY_MODE) else $error("mode not entered");
   a_data_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      (CORE_STALL && !done_now) |=> $stable(PAGE_DATA_BYTE1))
      else $error("data changed while busy");
   a_check_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      (done_now && op_reg == CMD_PAGE_CHECK && mem[{page_addr, 2'b00}] !=
       data_reg[0]) |=> NV_COMMAND_REG != STATUS_OK)
      else $error("mismatch read as zero");
endmodule
`default_nettype wire
